// >>> urs_defs.svh
// offsets, field positions, reset values and counts of the receiver block
// assumes a 32-bit AXI4-Lite register window with byte addresses
`ifndef URS_DEFS_SVH
`define URS_DEFS_SVH
`define URS_CTRL_OFS 8'h00
`define URS_STAT_OFS 8'h04
`define URS_MASK_OFS 8'h08
`define URS_DATA_OFS 8'h0c
`define URS_DIV_OFS 8'h10
`define URS_CTRL_LEN 0
`define URS_CTRL_PARINH 2
`define URS_CTRL_EVEN 3
`define URS_CTRL_RXDIS 4
`define URS_CTRL_FLDIS 5
`define URS_CTRL_MRST 6
`define URS_ST_RCVD 0
`define URS_ST_PARERR 1
`define URS_ST_FRMERR 2
`define URS_ST_OE 3
`define URS_CTRL_RST 6'h07
`define URS_MASK_RST 4'h0
`define URS_DIV_RST 16'h032c
`define URS_TICKS_PER_BIT 5'h10
`define URS_START_CENTRE 4'h7
`define URS_TX_IDLE_TICKS 5'h12
`define URS_RESP_OKAY 2'h0
`define URS_RESP_SLVERR 2'h2
`endif

// >>> urs_pkg.sv
// types and shared helpers of the receiver block
// assumes nothing beyond the defs header
package urs_pkg;
	typedef enum logic [2:0] {
		RX_HUNT,
		RX_START,
		RX_DATA,
		RX_PARITY,
		RX_STOP
	} urs_rx_state_t;

	typedef logic [1:0] urs_len_sel_t;

	// number of data bits from the two-bit length select
	function automatic logic [3:0] urs_char_bits(urs_len_sel_t sel);
		urs_char_bits = 4'h5 + {2'h0, sel};
	endfunction : urs_char_bits

	// byte-lane merge for register writes
	function automatic logic [31:0] urs_merge(logic [31:0] old, logic [31:0] nw,
			logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = nw[8*i +: 8];
			end
		end
		urs_merge = res;
	endfunction : urs_merge
endpackage : urs_pkg

// >>> urs_rx_if.sv
// carrier between the register side and the serial receive engine
// assumes both ends run on the one system clock
`timescale 1ns/100ps
interface urs_rx_if;
	logic tick;
	logic line;
	urs_pkg::urs_len_sel_t lenSel;
	logic parityInhibit;
	logic evenSel;
	logic charDone;
	logic [7:0] charData;
	logic parityBad;
	logic frameBad;

	modport engine (input tick, line, lenSel, parityInhibit, evenSel,
		output charDone, charData, parityBad, frameBad);
	modport ctrl (output tick, line, lenSel, parityInhibit, evenSel,
		input charDone, charData, parityBad, frameBad);
endinterface : urs_rx_if

// >>> urs_rx_core.sv
// serial receive engine: start hunt, mid-bit sampling, character assembly
// assumes a one-cycle 16x tick and an already synchronised line
`timescale 1ns/100ps
`include "urs_defs.svh"
module urs_rx_core (
	input wire logic clock, // system clock
	input wire logic reset, // sync, active high
	urs_rx_if.engine rx // config in, characters out
);
	urs_pkg::urs_rx_state_t state_q, state_d;
	logic [3:0] cnt_q, cnt_d;
	logic [3:0] bits_q, bits_d;
	logic [7:0] shift_q, shift_d;
	logic par_q, par_d;
	logic done_q, done_d;
	logic [7:0] data_q, data_d;
	logic parErr_q, parErr_d;
	logic frmErr_q, frmErr_d;
	logic [3:0] nBits;

	assign nBits = urs_pkg::urs_char_bits(rx.lenSel);
	assign rx.charDone = done_q;
	assign rx.charData = data_q;
	assign rx.parityBad = parErr_q;
	assign rx.frameBad = frmErr_q;

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		bits_d = bits_q;
		shift_d = shift_q;
		par_d = par_q;
		done_d = 1'b0;
		data_d = data_q;
		parErr_d = parErr_q;
		frmErr_d = frmErr_q;
		if (rx.tick) begin
			cnt_d = cnt_q + 4'h1;
			unique case (state_q)
				urs_pkg::RX_HUNT: begin
					// idle line is high, so any low level is a start edge
					if (!rx.line) begin
						state_d = urs_pkg::RX_START;
						cnt_d = 4'h0;
					end
				end
				urs_pkg::RX_START: begin
					if (cnt_q == `URS_START_CENTRE) begin
						cnt_d = 4'h0;
						bits_d = 4'h0;
						par_d = 1'b0;
						// a glitch shorter than half a bit is dropped
						state_d = rx.line ? urs_pkg::RX_HUNT : urs_pkg::RX_DATA;
					end
				end
				urs_pkg::RX_DATA: begin
					if (cnt_q == 4'hf) begin
						shift_d = {rx.line, shift_q[7:1]};
						par_d = par_q ^ rx.line;
						bits_d = bits_q + 4'h1;
						if (bits_q == nBits - 4'h1) begin
							state_d = rx.parityInhibit ? urs_pkg::RX_STOP : urs_pkg::RX_PARITY;
						end
					end
				end
				urs_pkg::RX_PARITY: begin
					if (cnt_q == 4'hf) begin
						par_d = par_q ^ rx.line;
						state_d = urs_pkg::RX_STOP;
					end
				end
				urs_pkg::RX_STOP: begin
					if (cnt_q == 4'hf) begin
						done_d = 1'b1;
						data_d = shift_q >> (4'h8 - nBits);
						parErr_d = !rx.parityInhibit && (par_q == rx.evenSel);
						frmErr_d = !rx.line;
						state_d = urs_pkg::RX_HUNT;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state_q <= urs_pkg::RX_HUNT;
			cnt_q <= 4'h0;
			bits_q <= 4'h0;
			shift_q <= 8'h00;
			par_q <= 1'b0;
			done_q <= 1'b0;
			data_q <= 8'h00;
			parErr_q <= 1'b0;
			frmErr_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			bits_q <= bits_d;
			shift_q <= shift_d;
			par_q <= par_d;
			done_q <= done_d;
			data_q <= data_d;
			parErr_q <= parErr_d;
			frmErr_q <= frmErr_d;
		end
	end

	a_start_centre: assert property (@(posedge clock) disable iff (reset)
		state_q == urs_pkg::RX_START && rx.tick && cnt_q == 4'h7 && !rx.line
		|=> state_q == urs_pkg::RX_DATA && cnt_q == 4'h0)
		else $error("start centre not taken at count seven");
	a_hunt_after_stop: assert property (@(posedge clock) disable iff (reset)
		done_q |-> state_q == urs_pkg::RX_HUNT)
		else $error("not hunting after stop centre");
	a_parity_inhib: assert property (@(posedge clock) disable iff (reset)
		$rose(done_q) && rx.parityInhibit |-> !parErr_q)
		else $error("parity error while inhibited");
	a_frame_check: assert property (@(posedge clock) disable iff (reset)
		state_q == urs_pkg::RX_STOP && rx.tick && cnt_q == 4'hf
		|=> frmErr_q == !$past(rx.line))
		else $error("framing flag wrong");
	c_false_start: cover property (@(posedge clock) disable iff (reset)
		state_q == urs_pkg::RX_START ##1 state_q == urs_pkg::RX_HUNT);
endmodule : urs_rx_core

// >>> urs_top.sv
// receive half of an async serial port behind an AXI4-Lite slave
// assumes one 125 MHz clock, a synchronous active-high reset, async line
`timescale 1ns/100ps
`include "urs_defs.svh"
module urs_top #(
	parameter int ADDR_W = 8,
	parameter logic [15:0] DIV_RESET = `URS_DIV_RST
) (
	input wire logic clock, // 125 MHz system clock
	input wire logic reset, // sync, active high
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [ADDR_W-1:0] s_axi_awaddr, // write byte address
	input wire logic [2:0] s_axi_awprot, // unused protection
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // byte enables
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	output logic [1:0] s_axi_bresp, // write response
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	input wire logic [ADDR_W-1:0] s_axi_araddr, // read byte address
	input wire logic [2:0] s_axi_arprot, // unused protection
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	input wire logic rx_serial_in, // async serial line
	output logic [7:0] rx_char_out, // received character
	output logic rx_char_oe, // character outputs driven
	output logic parity_err_flag, // parity error
	output logic framing_err_flag, // framing error
	output logic overrun_err_flag, // overrun error
	output logic data_received_flag, // character waiting
	output logic tx_buffer_empty_flag, // no transmit data held
	output logic status_flags_oe, // flag outputs driven
	output logic tx_serial_out, // idle transmit line
	output logic irq // level interrupt
);
	urs_rx_if rx ();

	// ******************************
	// line synchroniser and divider
	// ******************************
	logic sync1_q, sync2_q;
	logic [15:0] divCnt_q, divCnt_d;
	logic tick_q, tick_d;
	logic [15:0] div_q, div_d;
	logic [5:0] ctrl_q, ctrl_d;
	logic mrst_q, mrst_d;
	logic coreRst;

	assign coreRst = reset || mrst_q;

	always_ff @(posedge clock) begin
		if (reset) begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
		end else begin
			sync1_q <= rx_serial_in;
			sync2_q <= sync1_q;
		end
	end

	always_comb begin
		divCnt_d = divCnt_q + 16'h0001;
		tick_d = 1'b0;
		if (divCnt_q >= div_q) begin
			divCnt_d = 16'h0000;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			divCnt_q <= 16'h0000;
			tick_q <= 1'b0;
		end else begin
			divCnt_q <= divCnt_d;
			tick_q <= tick_d;
		end
	end

	assign rx.tick = tick_q;
	assign rx.line = sync2_q;
	assign rx.lenSel = ctrl_q[`URS_CTRL_LEN +: 2];
	assign rx.parityInhibit = ctrl_q[`URS_CTRL_PARINH];
	assign rx.evenSel = ctrl_q[`URS_CTRL_EVEN];

	urs_rx_core u_core (
		.clock(clock),
		.reset(coreRst),
		.rx(rx.engine)
	);

	// ******************************
	// AXI4-Lite slave
	// ******************************
	logic awHave_q, awHave_d, wHave_q, wHave_d;
	logic awReady_q, awReady_d, wReady_q, wReady_d;
	logic [ADDR_W-1:0] awAddr_q, awAddr_d;
	logic [31:0] wData_q, wData_d;
	logic [3:0] wStrb_q, wStrb_d;
	logic bValid_q, bValid_d, arReady_q, arReady_d, rValid_q, rValid_d;
	logic [1:0] bResp_q, bResp_d, rResp_q, rResp_d;
	logic [31:0] rData_q, rData_d;
	logic doWrite;
	logic [3:0] stat_q, stat_d, mask_q, mask_d;
	logic [7:0] rxBuf_q, rxBuf_d;

	function automatic logic isMapped(logic [ADDR_W-1:0] a);
		logic [7:0] b;
		b = a[7:0];
		isMapped = (b == `URS_CTRL_OFS) || (b == `URS_STAT_OFS) ||
			(b == `URS_MASK_OFS) || (b == `URS_DATA_OFS) || (b == `URS_DIV_OFS);
	endfunction : isMapped

	function automatic logic [31:0] readMux(logic [ADDR_W-1:0] a);
		readMux = 32'h0000_0000;
		unique case (a[7:0])
			`URS_CTRL_OFS: readMux = {26'h0, ctrl_q};
			`URS_STAT_OFS: readMux = {28'h0, stat_q};
			`URS_MASK_OFS: readMux = {28'h0, mask_q};
			`URS_DATA_OFS: readMux = {24'h0, rxBuf_q};
			`URS_DIV_OFS: readMux = {16'h0, div_q};
			default: readMux = 32'h0000_0000;
		endcase
	endfunction : readMux

	always_comb begin
		awHave_d = awHave_q;
		awAddr_d = awAddr_q;
		wHave_d = wHave_q;
		wData_d = wData_q;
		wStrb_d = wStrb_q;
		bValid_d = bValid_q;
		bResp_d = bResp_q;
		rValid_d = rValid_q;
		rData_d = rData_q;
		rResp_d = rResp_q;
		doWrite = 1'b0;
		if (s_axi_awvalid && awReady_q) begin
			awHave_d = 1'b1;
			awAddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && wReady_q) begin
			wHave_d = 1'b1;
			wData_d = s_axi_wdata;
			wStrb_d = s_axi_wstrb;
		end
		if (bValid_q && s_axi_bready) begin
			bValid_d = 1'b0;
		end
		if (awHave_q && wHave_q && !bValid_q) begin
			doWrite = 1'b1;
			awHave_d = 1'b0;
			wHave_d = 1'b0;
			bValid_d = 1'b1;
			bResp_d = isMapped(awAddr_q) ? `URS_RESP_OKAY : `URS_RESP_SLVERR;
		end
		if (rValid_q && s_axi_rready) begin
			rValid_d = 1'b0;
		end
		if (s_axi_arvalid && arReady_q) begin
			rValid_d = 1'b1;
			rData_d = readMux(s_axi_araddr);
			rResp_d = isMapped(s_axi_araddr) ? `URS_RESP_OKAY : `URS_RESP_SLVERR;
		end
		awReady_d = !awHave_d;
		wReady_d = !wHave_d;
		arReady_d = !rValid_d;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			awHave_q <= 1'b0;
			awAddr_q <= '0;
			wHave_q <= 1'b0;
			wData_q <= 32'h0000_0000;
			wStrb_q <= 4'h0;
			awReady_q <= 1'b0;
			wReady_q <= 1'b0;
			arReady_q <= 1'b0;
			bValid_q <= 1'b0;
			bResp_q <= `URS_RESP_OKAY;
			rValid_q <= 1'b0;
			rData_q <= 32'h0000_0000;
			rResp_q <= `URS_RESP_OKAY;
		end else begin
			awHave_q <= awHave_d;
			awAddr_q <= awAddr_d;
			wHave_q <= wHave_d;
			wData_q <= wData_d;
			wStrb_q <= wStrb_d;
			awReady_q <= awReady_d;
			wReady_q <= wReady_d;
			arReady_q <= arReady_d;
			bValid_q <= bValid_d;
			bResp_q <= bResp_d;
			rValid_q <= rValid_d;
			rData_q <= rData_d;
			rResp_q <= rResp_d;
		end
	end

	assign s_axi_awready = awReady_q;
	assign s_axi_wready = wReady_q;
	assign s_axi_bvalid = bValid_q;
	assign s_axi_bresp = bResp_q;
	assign s_axi_arready = arReady_q;
	assign s_axi_rvalid = rValid_q;
	assign s_axi_rdata = rData_q;
	assign s_axi_rresp = rResp_q;

	// ******************************
	// registers, flags and pins
	// ******************************
	logic [3:0] statClr, statSet;
	logic [31:0] merged;
	logic irq_q, charOe_q, flagOe_q, tbe_q, txOut_q;
	logic [4:0] txCnt_q, txCnt_d;

	assign merged = urs_pkg::urs_merge({16'h0, div_q}, wData_q, wStrb_q);

	always_comb begin
		ctrl_d = ctrl_q;
		mask_d = mask_q;
		div_d = div_q;
		mrst_d = 1'b0;
		statClr = 4'h0;
		if (doWrite && awAddr_q[7:0] == `URS_CTRL_OFS && wStrb_q[0]) begin
			ctrl_d = wData_q[5:0];
			mrst_d = wData_q[`URS_CTRL_MRST];
		end
		if (doWrite && awAddr_q[7:0] == `URS_MASK_OFS && wStrb_q[0]) begin
			mask_d = wData_q[3:0];
		end
		if (doWrite && awAddr_q[7:0] == `URS_DIV_OFS) begin
			div_d = merged[15:0];
		end
		if (doWrite && awAddr_q[7:0] == `URS_STAT_OFS && wStrb_q[0]) begin
			statClr = wData_q[3:0];
		end
		statSet = 4'h0;
		rxBuf_d = rxBuf_q;
		if (rx.charDone) begin
			rxBuf_d = rx.charData;
			statSet[`URS_ST_RCVD] = 1'b1;
			statSet[`URS_ST_PARERR] = rx.parityBad;
			statSet[`URS_ST_FRMERR] = rx.frameBad;
			statSet[`URS_ST_OE] = stat_q[`URS_ST_RCVD];
		end
		// a new event beats a clear landing in the same cycle
		stat_d = (stat_q & ~statClr) | statSet;
		txCnt_d = txCnt_q;
		if (tick_q && txCnt_q != `URS_TX_IDLE_TICKS) begin
			txCnt_d = txCnt_q + 5'h01;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			ctrl_q <= `URS_CTRL_RST;
			mask_q <= `URS_MASK_RST;
			div_q <= DIV_RESET;
			mrst_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			mask_q <= mask_d;
			div_q <= div_d;
			mrst_q <= mrst_d;
		end
	end

	always_ff @(posedge clock) begin
		if (coreRst) begin
			stat_q <= 4'h0;
			rxBuf_q <= 8'h00;
			txCnt_q <= 5'h00;
			txOut_q <= 1'b0;
			irq_q <= 1'b0;
			charOe_q <= 1'b0;
			flagOe_q <= 1'b0;
			tbe_q <= 1'b0;
		end else begin
			stat_q <= stat_d;
			rxBuf_q <= rxBuf_d;
			txCnt_q <= txCnt_d;
			txOut_q <= txCnt_q == `URS_TX_IDLE_TICKS;
			irq_q <= |(stat_q & mask_q);
			charOe_q <= !ctrl_q[`URS_CTRL_RXDIS];
			flagOe_q <= !ctrl_q[`URS_CTRL_FLDIS];
			// no transmitter here, so its buffer reads empty except while reset or master reset holds it low
			tbe_q <= 1'b1;
		end
	end

	assign rx_char_out = rxBuf_q;
	assign rx_char_oe = charOe_q;
	assign data_received_flag = stat_q[`URS_ST_RCVD];
	assign parity_err_flag = stat_q[`URS_ST_PARERR];
	assign framing_err_flag = stat_q[`URS_ST_FRMERR];
	assign overrun_err_flag = stat_q[`URS_ST_OE];
	assign tx_buffer_empty_flag = tbe_q;
	assign status_flags_oe = flagOe_q;
	assign tx_serial_out = txOut_q;
	assign irq = irq_q;

	// ******************************
	// assertions
	// ******************************
	a_dr_rises: assert property (@(posedge clock) disable iff (coreRst)
		rx.charDone |=> data_received_flag)
		else $error("data received not set after character");
	a_overrun_set: assert property (@(posedge clock) disable iff (coreRst)
		rx.charDone && data_received_flag |=> overrun_err_flag)
		else $error("overrun missed");
	a_buf_disable: assert property (@(posedge clock) disable iff (coreRst)
		ctrl_q[`URS_CTRL_RXDIS] [*2] |-> !rx_char_oe)
		else $error("character outputs driven while disabled");
	a_flag_disable: assert property (@(posedge clock) disable iff (coreRst)
		ctrl_q[`URS_CTRL_FLDIS] [*2] |-> !status_flags_oe)
		else $error("flags driven while disabled");
	a_right_just: assert property (@(posedge clock) disable iff (coreRst)
		rx.charDone && rx.lenSel == 2'h0 |=> rx_char_out[7:5] == 3'h0)
		else $error("five-bit character not right justified");
	a_clear_works: assert property (@(posedge clock) disable iff (coreRst)
		statClr[`URS_ST_RCVD] && !rx.charDone |=> !data_received_flag)
		else $error("data received not cleared");
	a_mrst_flags: assert property (@(posedge clock) disable iff (reset)
		mrst_q |=> stat_q == 4'h0 && !tx_serial_out)
		else $error("master reset did not clear flags");
	a_tick_period: assert property (@(posedge clock) disable iff (reset)
		tick_q && div_q != 16'h0000 && div_q == $past(div_q) |=> !tick_q)
		else $error("tick not a single pulse");
	a_irq_level: assert property (@(posedge clock) disable iff (coreRst)
		|(stat_q & mask_q) |=> irq)
		else $error("interrupt not raised");
	a_wr_answer: assert property (@(posedge clock) disable iff (reset)
		awHave_q && wHave_q && !bValid_q |=> s_axi_bvalid)
		else $error("write response late");
	c_char: cover property (@(posedge clock) rx.charDone);
	c_overrun: cover property (@(posedge clock) rx.charDone && data_received_flag);
	c_frame: cover property (@(posedge clock) rx.charDone && rx.frameBad);
	c_parity: cover property (@(posedge clock) rx.charDone && rx.parityBad);
endmodule : urs_top

// >>> urs_line_sender.sv
// far-side serial transmitter model driving the receive line
// assumes the bench ticks at 16x bit rate on every clock (divider set to 0)
`timescale 1ns/100ps
module urs_line_sender (
	input wire logic clock, // bench clock, one 16x tick per cycle
	output logic line // serial line into the receiver
);
	// ************
	// line driver
	// ************
	initial line = 1'h1;

	task automatic hold(input logic v, input int ticks);
		@(posedge clock);
		line <= v;
		repeat (ticks - 1) @(posedge clock);
	endtask : hold

	// one frame, then idle high; flips and short stop are for fault scenarios
	task automatic send(input logic [7:0] d, input int nBits, input bit parEn, input bit even,
			input bit flipPar, input bit badStop, input int stopTicks);
		logic p;
		p = 1'h0;
		hold(1'h0, 16);
		for (int i = 0; i < nBits; i++) begin
			hold(d[i], 16);
			p = p ^ d[i];
		end
		if (parEn) begin
			hold((even ? p : ~p) ^ flipPar, 16);
		end
		hold(~badStop, stopTicks);
		@(posedge clock);
		line <= 1'h1;
	endtask : send
endmodule : urs_line_sender

// >>> uart_receiver_status_test.sv
// self-checking bench of the receiver block over AXI4-Lite
// assumes the divider is written to 0 so each clock is one 16x tick
`timescale 1ns/100ps
`include "urs_defs.svh"
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin \
	$display("[ERR] %s expected %h seen %h", nm, ex, got); fails++; end end
module uart_receiver_status_test;
	logic clock = 1'h0, reset = 1'h1;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'hf;
	logic [1:0] bresp, rresp, rsp;
	logic awready, wready, bvalid, arready, rvalid, line;
	logic [7:0] charOut;
	logic charOe, parFlag, frmFlag, oeFlag, rcvFlag, tbeFlag, flagOe, txOut, irq;
	logic [31:0] rd;
	logic [7:0] d;
	int fails = 0, checks = 0;

	always #4 clock = ~clock;

	urs_line_sender i_sender (.clock(clock), .line(line));

	urs_top i_dut (.clock(clock), .reset(reset), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.rx_serial_in(line), .rx_char_out(charOut), .rx_char_oe(charOe),
		.parity_err_flag(parFlag), .framing_err_flag(frmFlag), .overrun_err_flag(oeFlag),
		.data_received_flag(rcvFlag), .tx_buffer_empty_flag(tbeFlag),
		.status_flags_oe(flagOe), .tx_serial_out(txOut), .irq(irq));

	// ************
	// bus tasks
	// ************
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] v);
		int n;
		bit aw, w;
		aw = 0;
		w = 0;
		n = 0;
		@(posedge clock);
		awvalid <= 1'h1;
		awaddr <= a;
		wvalid <= 1'h1;
		wdata <= v;
		bready <= 1'h1;
		while (n < 1000) begin
			@(posedge clock);
			n++;
			if (!aw && awready) begin aw = 1; awvalid <= 1'h0; end
			if (!w && wready) begin w = 1; wvalid <= 1'h0; end
			if (bvalid) begin rsp = bresp; break; end
		end
		bready <= 1'h0;
		if (n >= 1000) fails++;
	endtask : axiWrite

	task automatic axiRead(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge clock);
		arvalid <= 1'h1;
		araddr <= a;
		rready <= 1'h1;
		while (n < 1000) begin
			@(posedge clock);
			n++;
			if (arready) arvalid <= 1'h0;
			if (rvalid) begin rd = rdata; rsp = rresp; break; end
		end
		rready <= 1'h0;
		if (n >= 1000) fails++;
	endtask : axiRead

	task automatic rdChk(input logic [7:0] a, input logic [31:0] ex);
		axiRead(a);
		`CHK("read data", ex, rd)
	endtask : rdChk

	// frame with length select and parity mode 0 none, 1 odd, 2 even
	task automatic frame(input logic [7:0] v, input int len, input int pm, input bit fp,
			input bit bs, input int st);
		i_sender.send(v, 5 + len, pm != 0, pm == 2, fp, bs, st);
		repeat (40) @(posedge clock);
	endtask : frame

	function automatic logic [7:0] expChar(input logic [7:0] v, input int len);
		return v & (8'hff >> (3 - len));
	endfunction : expChar

	function automatic logic [31:0] ctrlOf(input int len, input int pm);
		return len | (pm == 0 ? 4 : 0) | (pm == 2 ? 8 : 0);
	endfunction : ctrlOf

	task automatic clearAll();
		axiWrite(`URS_STAT_OFS, 32'hf);
		repeat (2) @(posedge clock);
		`CHK("received cleared", 1'h0, rcvFlag)
	endtask : clearAll

	task automatic test_done();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : test_done

	initial begin
		#200000;
		fails++;
		test_done();
	end

	// ************
	// scenarios
	// ************
	initial begin
		void'($urandom(97));
		repeat (3) @(posedge clock);
		reset <= 1'h0;
		@(posedge clock);
		rdChk(`URS_CTRL_OFS, 32'h07);
		rdChk(`URS_MASK_OFS, 32'h0);
		rdChk(`URS_DIV_OFS, 32'h032c);
		rdChk(`URS_STAT_OFS, 32'h0);
		`CHK("tx empty", 1'h1, tbeFlag)
		rdChk(8'h14, 32'h0);
		`CHK("unmapped rresp", `URS_RESP_SLVERR, rsp)
		axiWrite(8'h14, 32'h1);
		`CHK("unmapped bresp", `URS_RESP_SLVERR, rsp)
		axiWrite(`URS_DIV_OFS, 32'h0);
		$display("test registers done");
		for (int len = 0; len < 4; len++) begin
			for (int pm = 0; pm < 3; pm++) begin
				d = 8'($urandom);
				axiWrite(`URS_CTRL_OFS, ctrlOf(len, pm));
				frame(d, len, pm, 0, 0, 16);
				`CHK("received set", 1'h1, rcvFlag)
				`CHK("char", expChar(d, len), charOut)
				`CHK("parity clean", 1'h0, parFlag)
				`CHK("framing clean", 1'h0, frmFlag)
				rdChk(`URS_DATA_OFS, {24'h0, expChar(d, len)});
				clearAll();
			end
		end
		$display("test formats done");
		axiWrite(`URS_CTRL_OFS, ctrlOf(3, 1));
		frame(8'h5a, 3, 1, 1, 0, 16);
		`CHK("parity error", 1'h1, parFlag)
		clearAll();
		frame(8'ha5, 3, 1, 0, 1, 16);
		`CHK("framing error", 1'h1, frmFlag)
		clearAll();
		axiWrite(`URS_CTRL_OFS, 32'h07);
		@(posedge clock);
		// the line belongs to the sender model, so the glitch goes through it
		i_sender.hold(1'h0, 4);
		i_sender.hold(1'h1, 1);
		repeat (300) @(posedge clock);
		`CHK("false start", 1'h0, rcvFlag)
		$display("test errors done");
		axiWrite(`URS_MASK_OFS, 32'h8);
		d = 8'($urandom);
		i_sender.send(8'h3c, 8, 0, 0, 0, 0, 12);
		frame(d, 3, 0, 0, 0, 16);
		`CHK("back to back", d, charOut)
		`CHK("overrun", 1'h1, oeFlag)
		`CHK("irq set", 1'h1, irq)
		clearAll();
		`CHK("irq clear", 1'h0, irq)
		axiWrite(`URS_MASK_OFS, 32'h0);
		frame(8'h81, 3, 0, 0, 0, 16);
		`CHK("irq masked", 1'h0, irq)
		$display("test overrun done");
		axiWrite(`URS_CTRL_OFS, 32'h17);
		repeat (2) @(posedge clock);
		`CHK("char float", 1'h0, charOe)
		axiWrite(`URS_CTRL_OFS, 32'h27);
		repeat (2) @(posedge clock);
		`CHK("flags float", 1'h0, flagOe)
		`CHK("char back", 1'h1, charOe)
		axiWrite(`URS_CTRL_OFS, 32'h47);
		repeat (3) @(posedge clock);
		`CHK("master reset received", 1'h0, rcvFlag)
		`CHK("master reset tx low", 1'h0, txOut)
		repeat (25) @(posedge clock);
		`CHK("master reset tx high", 1'h1, txOut)
		rdChk(`URS_CTRL_OFS, 32'h07);
		$display("test master reset done");
		test_done();
	end
endmodule : uart_receiver_status_test
